// ===== bench/wdc_watchdog_tb.sv
`timescale 1ns/1ps
`include "wdc_consts.svh"

`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end

module wdc_watchdog_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [3:0] stall_in = 4'h0;
    logic dog_irq;
    logic system_reset;
    int miscompares = 0;
    int samples_checked = 0;
    int rst_pulses = 0;
    int p0;
    logic [31:0] d;
    logic [31:0] a;
    logic [31:0] b;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rx [7] = '{32'hFFFF, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
    logic [31:0] sbit [4] = '{32'h10, 32'h08, 32'h04, 32'h04};

    // Short divider keeps expiry waits to a few hundred cycles
    wdc_watchdog #(.DEC_CYCLES(4)) DUT (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .debug_active(stall_in[0]),
        .week_timer_active(stall_in[1]),
        .hib_timer0_active(stall_in[2]),
        .hib_timer1_active(stall_in[3]),
        .dog_irq(dog_irq),
        .system_reset(system_reset)
    );

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        if (system_reset === 1'b1)
            rst_pulses++;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Both reads see the same latency, so 40 edges apart gives exactly ten ticks
    task automatic measure(input logic [31:0] exp, input string what);
        rd(`WDC_OFS_COUNT, a);
        repeat (38) @(posedge sys_clk);
        rd(`WDC_OFS_COUNT, b);
        `CHK(what, exp, a - b)
    endtask

    task automatic wait_out(input bit pick, input string what);
        int n;
        for (n = 0; n < 400; n++)
        begin
            @(posedge sys_clk);
            #1;
            if ((pick ? system_reset : dog_irq) === 1'b1)
                break;
        end
        if (n == 400)
        begin
            miscompares++;
            $display("unexpected %s: expected 1 seen timeout", what);
            end_of_test();
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(ra[i], d);
            `CHK("reset value", rx[i], d)
        end
        $display("test reset_values done");

        wr(`WDC_OFS_RELOAD, 32'h10);
        rd(`WDC_OFS_COUNT, d);
        `CHK("count after reload write", 32'h10, d)
        wr(`WDC_OFS_CTRL, 32'h1);
        repeat (20) @(posedge sys_clk);
        wr(`WDC_OFS_CTRL, 32'h0);
        rd(`WDC_OFS_COUNT, a);
        `CHK("count moved while enabled", 1'b1, a < 32'h10)
        wr(`WDC_OFS_KICK, 32'hFF);
        rd(`WDC_OFS_COUNT, b);
        `CHK("count after disabled kick", a, b)
        measure(32'h0, "disabled delta");
        wr(`WDC_OFS_CTRL, 32'h1);
        rd(`WDC_OFS_COUNT, d);
        `CHK("count after enable", 32'h10, d)
        measure(32'hA, "enabled delta");
        wr(`WDC_OFS_CTRL, 32'h0);
        $display("test enable_kick done");

        wr(`WDC_OFS_RELOAD, 32'h100);
        for (int i = 0; i < 4; i++)
        begin
            wr(`WDC_OFS_CTRL, 32'h1 | sbit[i]);
            wr(`WDC_OFS_KICK, 32'h5A);
            rd(`WDC_OFS_COUNT, d);
            `CHK("count after kick", 32'h100, d)
            @(posedge sys_clk);
            stall_in[i] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            measure(32'h0, "stalled delta");
            wr(`WDC_OFS_CTRL, 32'h1);
            measure(32'hA, "unstalled delta");
            wr(`WDC_OFS_CTRL, 32'h1 | sbit[i]);
            @(posedge sys_clk);
            stall_in[i] <= 1'b0;
            repeat (4) @(posedge sys_clk);
            measure(32'hA, "resumed delta");
        end
        wr(`WDC_OFS_CTRL, 32'h0);
        $display("test stall done");

        wr(`WDC_OFS_RELOAD, 32'h40);
        wr(`WDC_OFS_IRQ_EN, 32'h1);
        p0 = rst_pulses;
        wr(`WDC_OFS_CTRL, 32'h201);
        wait_out(1'b0, "interrupt on expiry");
        `CHK("reset pulses in irq mode", p0, rst_pulses)
        rd(`WDC_OFS_CTRL, d);
        `CHK("control after irq expiry", 32'h1, d)
        wr(`WDC_OFS_CTRL, 32'h0);
        rd(`WDC_OFS_STATUS, d);
        `CHK("pending after expiry", 32'h1, d)
        wr(`WDC_OFS_STATUS, 32'h0);
        rd(`WDC_OFS_STATUS, d);
        `CHK("pending after write 0", 32'h1, d)
        wr(`WDC_OFS_IRQ_EN, 32'h0);
        settle();
        `CHK("irq masked", 1'b0, dog_irq)
        wr(`WDC_OFS_IRQ_EN, 32'h1);
        settle();
        `CHK("irq unmasked", 1'b1, dog_irq)
        wr(`WDC_OFS_STATUS, 32'h1);
        settle();
        `CHK("irq after clear", 1'b0, dog_irq)
        rd(`WDC_OFS_STATUS, d);
        `CHK("pending after write 1", 32'h0, d)
        $display("test expiry_irq done");

        wr(`WDC_OFS_RELOAD, 32'h2);
        p0 = rst_pulses;
        wr(`WDC_OFS_CTRL, 32'h1);
        wait_out(1'b1, "reset on expiry");
        @(posedge sys_clk);
        #1;
        `CHK("reset pulse width", 1'b0, system_reset)
        `CHK("irq in reset mode", 1'b0, dog_irq)
        wr(`WDC_OFS_CTRL, 32'h0);
        `CHK("reset pulse count", p0 + 1, rst_pulses)
        rd(`WDC_OFS_STATUS, d);
        `CHK("pending in reset mode", 32'h0, d)
        $display("test expiry_reset done");
        end_of_test();
    end
endmodule // wdc_watchdog_tb

// ===== core/wdc_consts.svh
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

`define WDC_OFS_RELOAD 8'h00
`define WDC_OFS_CTRL 8'h04
`define WDC_OFS_KICK 8'h08
`define WDC_OFS_COUNT 8'h0C
`define WDC_OFS_STATUS 8'h10
`define WDC_OFS_IRQ_EN 8'h14

`define WDC_BIT_ENABLE 0
`define WDC_BIT_HIB_STALL 2
`define WDC_BIT_WEEK_STALL 3
`define WDC_BIT_DBG_STALL 4
`define WDC_BIT_IRQ_MODE 9
`define WDC_BIT_PENDING 0
`define WDC_BIT_IRQ_EN 0

`define WDC_RELOAD_RST 16'hFFFF
`define WDC_COUNT_RST 16'hFFFF

`define WDC_SYS_CLK_HZ 100000000
`define WDC_CORE_CLK_HZ 32768
`define WDC_CORE_PER_DEC 33
`define WDC_DEC_CYCLES ((`WDC_SYS_CLK_HZ / `WDC_CORE_CLK_HZ) * `WDC_CORE_PER_DEC)

`endif

// ===== core/wdc_pkg.sv
package wdc_pkg;

    localparam int WDC_IN_DBG = 0;
    localparam int WDC_IN_WEEK = 1;
    localparam int WDC_IN_HIB0 = 2;
    localparam int WDC_IN_HIB1 = 3;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic dog_enable;
        logic expiry_irq_mode;
        logic dbg_stall_en;
        logic week_stall_en;
        logic hib_stall_en;
        logic [15:0] reload;
        logic [15:0] count;
        logic [16:0] div;
        logic pending;
        logic irq_en;
        logic dog_irq;
        logic system_reset;
        logic [31:0] rdata;
    } wdc_state_t;

endpackage

// ===== core/wdc_watchdog.sv
`timescale 1ns/1ps
`include "wdc_consts.svh"

module wdc_watchdog
    import wdc_pkg::*;
#(
    parameter int DEC_CYCLES = `WDC_DEC_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic debug_active,
    input wire logic week_timer_active,
    input wire logic hib_timer0_active,
    input wire logic hib_timer1_active,
    output logic dog_irq,
    output logic system_reset
);

    localparam logic [16:0] DIV_LAST = 17'(DEC_CYCLES - 1);

    wdc_state_t st;
    wdc_state_t next_st;

    logic wr_reload;
    logic wr_ctrl;
    logic wr_kick;
    logic wr_status;
    logic wr_irq_en;
    logic dbg_hold;
    logic week_hold;
    logic hib_hold;
    logic stalled;
    logic dec_tick;
    logic kick_ok;
    logic start;
    logic expire;

    assign wr_reload = reg_wr && (reg_addr == `WDC_OFS_RELOAD);
    assign wr_ctrl = reg_wr && (reg_addr == `WDC_OFS_CTRL);
    assign wr_kick = reg_wr && (reg_addr == `WDC_OFS_KICK);
    assign wr_status = reg_wr && (reg_addr == `WDC_OFS_STATUS);
    assign wr_irq_en = reg_wr && (reg_addr == `WDC_OFS_IRQ_EN);

    // Stall sources are taken only from the second synchroniser stage
    assign dbg_hold = st.dbg_stall_en && st.sync2[WDC_IN_DBG];
    assign week_hold = st.week_stall_en && st.sync2[WDC_IN_WEEK];
    assign hib_hold = st.hib_stall_en
        && (st.sync2[WDC_IN_HIB0] || st.sync2[WDC_IN_HIB1]);
    assign stalled = dbg_hold || week_hold || hib_hold;

    assign dec_tick = st.dog_enable && !stalled && (st.div == DIV_LAST);
    assign kick_ok = wr_kick && st.dog_enable;
    assign start = wr_ctrl && reg_wdata[`WDC_BIT_ENABLE] && !st.dog_enable;
    assign expire = dec_tick && (st.count == 16'h0000) && !wr_reload && !kick_ok;

    always_comb
    begin
        next_st = st;
        next_st.sync1 = {hib_timer1_active, hib_timer0_active,
            week_timer_active, debug_active};
        next_st.sync2 = st.sync1;
        next_st.system_reset = 1'b0;

        if (wr_ctrl)
        begin
            next_st.dog_enable = reg_wdata[`WDC_BIT_ENABLE];
            next_st.expiry_irq_mode = reg_wdata[`WDC_BIT_IRQ_MODE];
            next_st.dbg_stall_en = reg_wdata[`WDC_BIT_DBG_STALL];
            next_st.week_stall_en = reg_wdata[`WDC_BIT_WEEK_STALL];
            next_st.hib_stall_en = reg_wdata[`WDC_BIT_HIB_STALL];
        end
        if (wr_irq_en)
        begin
            next_st.irq_en = reg_wdata[`WDC_BIT_IRQ_EN];
        end
        if (wr_reload)
        begin
            next_st.reload = reg_wdata[15:0];
        end

        // Divider only advances while running, so a stall freezes the phase too
        if (!st.dog_enable)
        begin
            next_st.div = '0;
        end
        else if (!stalled)
        begin
            next_st.div = dec_tick ? 17'h00000 : st.div + 17'h00001;
        end

        if (wr_reload)
        begin
            next_st.count = reg_wdata[15:0];
            next_st.div = '0;
        end
        else if (start || kick_ok)
        begin
            next_st.count = st.reload;
            next_st.div = '0;
        end
        else if (dec_tick)
        begin
            if (st.count == 16'h0000)
            begin
                // The event itself reloads, so a missed kick does not wrap to FFFF
                next_st.count = st.reload;
                if (st.expiry_irq_mode)
                begin
                    next_st.pending = 1'b1;
                    // A software write of one in the same cycle keeps the mode
                    next_st.expiry_irq_mode = wr_ctrl && reg_wdata[`WDC_BIT_IRQ_MODE];
                end
                else
                begin
                    next_st.system_reset = 1'b1;
                end
            end
            else
            begin
                next_st.count = st.count - 16'h0001;
            end
        end

        // An interrupt expiry in the same cycle as the clear wins, so no event is lost
        if (wr_status && reg_wdata[`WDC_BIT_PENDING] && !expire)
        begin
            next_st.pending = 1'b0;
        end
        if (wr_status && reg_wdata[`WDC_BIT_PENDING] && expire && !st.expiry_irq_mode)
        begin
            next_st.pending = 1'b0;
        end

        next_st.dog_irq = next_st.pending && next_st.irq_en;

        if (reg_rd)
        begin
            next_st.rdata = 32'h00000000;
            case (reg_addr)
                `WDC_OFS_RELOAD: next_st.rdata[15:0] = st.reload;
                `WDC_OFS_CTRL:
                begin
                    next_st.rdata[`WDC_BIT_ENABLE] = st.dog_enable;
                    next_st.rdata[`WDC_BIT_HIB_STALL] = st.hib_stall_en;
                    next_st.rdata[`WDC_BIT_WEEK_STALL] = st.week_stall_en;
                    next_st.rdata[`WDC_BIT_DBG_STALL] = st.dbg_stall_en;
                    next_st.rdata[`WDC_BIT_IRQ_MODE] = st.expiry_irq_mode;
                end
                `WDC_OFS_COUNT: next_st.rdata[15:0] = st.count;
                `WDC_OFS_STATUS: next_st.rdata[`WDC_BIT_PENDING] = st.pending;
                `WDC_OFS_IRQ_EN: next_st.rdata[`WDC_BIT_IRQ_EN] = st.irq_en;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st.sync1 <= 4'h0;
            st.sync2 <= 4'h0;
            st.dog_enable <= 1'b0;
            st.expiry_irq_mode <= 1'b0;
            st.dbg_stall_en <= 1'b0;
            st.week_stall_en <= 1'b0;
            st.hib_stall_en <= 1'b0;
            st.reload <= `WDC_RELOAD_RST;
            st.count <= `WDC_COUNT_RST;
            st.div <= 17'h00000;
            st.pending <= 1'b0;
            st.irq_en <= 1'b0;
            st.dog_irq <= 1'b0;
            st.system_reset <= 1'b0;
            st.rdata <= 32'h00000000;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign dog_irq = st.dog_irq;
    assign system_reset = st.system_reset;

    default clocking wdc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_expire_irq;
        expire && st.expiry_irq_mode && !wr_ctrl;
    endsequence

    sequence s_irq_taken;
        st.pending && !st.expiry_irq_mode;
    endsequence

    sequence s_reset_pulse;
        st.system_reset ##1 !st.system_reset;
    endsequence

    property p_irq_mode;
        s_expire_irq |=> s_irq_taken and !st.system_reset;
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("interrupt-mode expiry did not set pending and clear mode");

    property p_reset_mode;
        (expire && !st.expiry_irq_mode) |=> s_reset_pulse;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset-mode expiry did not give a one-cycle reset pulse");

    property p_dbg_stall;
        (dbg_hold && st.dog_enable && !wr_reload && !kick_ok) |=> $stable(st.count);
    endproperty
    a_dbg_stall: assert property (p_dbg_stall)
        else $error("counter moved during debug stall");

    property p_week_stall;
        (week_hold && st.dog_enable && !wr_reload && !kick_ok)
            |=> $stable(st.count) && $stable(st.div);
    endproperty
    a_week_stall: assert property (p_week_stall)
        else $error("counter moved during calendar stall");
    property p_hib_stall;
        (hib_hold && st.dog_enable && !wr_reload && !kick_ok) |=> $stable(st.count);
    endproperty
    a_hib_stall: assert property (p_hib_stall)
        else $error("counter moved during hibernation stall");

    property p_enable_write;
        wr_ctrl |=> st.dog_enable == $past(reg_wdata[`WDC_BIT_ENABLE]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit did not follow the control write");

    property p_kick_reads_zero;
        (reg_rd && reg_addr == `WDC_OFS_KICK) |=> reg_rdata == 32'h00000000;
    endproperty
    a_kick_reads_zero: assert property (p_kick_reads_zero)
        else $error("kick register read was not zero");

    property p_kick_load;
        (kick_ok && !wr_reload) |=> st.count == $past(st.reload) ##1 !system_reset;
    endproperty
    a_kick_load: assert property (p_kick_load)
        else $error("kick did not load the reload value");

    property p_kick_ignored;
        (wr_kick && !st.dog_enable && !wr_reload && !wr_ctrl) |=> $stable(st.count);
    endproperty
    a_kick_ignored: assert property (p_kick_ignored)
        else $error("kick changed the counter while disabled");

    property p_count_read;
        (reg_rd && reg_addr == `WDC_OFS_COUNT) |=> reg_rdata == {16'h0000, $past(st.count)};
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count read did not return the live counter");

    property p_w1c;
        (wr_status && reg_wdata[`WDC_BIT_PENDING] && !expire) |=> !st.pending;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("pending bit not cleared by writing one");

    property p_w0_keeps;
        (wr_status && !reg_wdata[`WDC_BIT_PENDING] && st.pending) |=> st.pending;
    endproperty
    a_w0_keeps: assert property (p_w0_keeps)
        else $error("writing zero changed the pending bit");

    property p_irq_gate;
        dog_irq == (st.pending && st.irq_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt output is not pending AND enable");

    property p_reload_write;
        wr_reload |=> st.count == $past(reg_wdata[15:0]) && st.reload == st.count;
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload write did not load the counter");

    property p_decrement;
        (dec_tick && st.count != 16'h0000 && !wr_reload && !kick_ok)
            |=> st.count == $past(st.count) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement by one on the tick");

    property p_no_early_dec;
        (st.dog_enable && st.div != DIV_LAST && !wr_reload && !kick_ok && !wr_ctrl)
            |=> $stable(st.count);
    endproperty
    a_no_early_dec: assert property (p_no_early_dec)
        else $error("counter changed between ticks");

    property p_disabled_hold;
        (!st.dog_enable && !wr_reload && !start) |=> $stable(st.count);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("counter moved while disabled");

    property p_start;
        (start && !wr_reload) |=> st.count == $past(st.reload) && st.div == 17'h00000;
    endproperty
    a_start: assert property (p_start)
        else $error("enabling did not start from the reload value");

endmodule // wdc_watchdog
